// ===== hdl/dmauci_core.v
// Purpose: user cycle request side of a 16-bit dma interface
// Assumes: user inputs synchronous to hclk; simple bus master port with grant
// Notes: registers over ahb-lite, zero wait states
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dmauci_defs.vh"
module dmauci_core (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output reg [31:0] hrdata,
	output wire hresp,
	input wire bus_init,
	input wire [15:0] user_data_in,
	input wire cycle_type_hi,
	input wire cycle_type_lo,
	input wire cycle_req_a,
	input wire cycle_req_b,
	input wire count_step_enable,
	input wire addr_step_enable,
	output reg [15:0] user_data_out,
	output wire busy,
	output wire end_cycle,
	output wire ready,
	output reg go_pulse,
	output wire npr_req,
	input wire npr_grant,
	output reg bus_active,
	output reg [17:0] bus_addr,
	output reg [1:0] bus_ctrl_n,
	output reg [15:0] bus_wdata,
	input wire [15:0] bus_rdata,
	input wire bus_done,
	output wire [2:0] irq_level,
	output wire [17:0] reg_base,
	output wire [8:0] irq_vector
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_REQ = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;
	localparam integer END_CYC = `DMAUCI_END_PULSE_CYC;
	localparam [7:0] END_LEN = END_CYC[7:0];

	reg [1:0] state_reg;
	reg cycle_reg;
	reg ready_reg;
	reg [15:0] word_count_reg;
	reg [15:0] bus_address_reg;
	reg [17:0] base_reg;
	reg [8:0] vector_reg;
	reg req_prev_reg;
	reg [1:0] cur_type_reg;
	reg end_trig;
	reg wr_pend_reg;
	reg [11:0] wr_addr_reg;
	wire req_or;
	wire req_fall;
	wire [15:0] data_buffer_reg;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq_level = `DMAUCI_PRIO_LEVEL;
	assign reg_base = base_reg;
	assign irq_vector = vector_reg;
	assign data_buffer_reg = user_data_in;
	assign busy = cycle_reg | (state_reg != ST_IDLE);
	assign ready = ready_reg;
	assign npr_req = (state_reg == ST_REQ);
	assign req_or = cycle_req_a | cycle_req_b;
	assign req_fall = req_prev_reg & ~req_or;

	// address phase capture; zero wait states so hready from this slave only
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end else if (hready) begin
			wr_pend_reg <= hsel & htrans[1] & hwrite;
			wr_addr_reg <= haddr[11:0];
		end
	end

	// read data comes from the address phase so it stands in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (hready & hsel & htrans[1] & ~hwrite) begin
			if (haddr[11:0] == `DMAUCI_OFF_CTRL) begin
				hrdata <= {23'h000000, cycle_reg, ready_reg, 7'h00};
			end else if (haddr[11:0] == `DMAUCI_OFF_WC) begin
				hrdata <= {16'h0000, word_count_reg};
			end else if (haddr[11:0] == `DMAUCI_OFF_BA) begin
				hrdata <= {16'h0000, bus_address_reg};
			end else if (haddr[11:0] == `DMAUCI_OFF_DB) begin
				hrdata <= {16'h0000, data_buffer_reg};
			end else if (haddr[11:0] == `DMAUCI_OFF_CFG) begin
				hrdata <= {5'h00, vector_reg, base_reg};
			end else begin
				hrdata <= 32'h00000000;
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_prev_reg <= 1'b0;
		end else begin
			req_prev_reg <= req_or;
		end
	end

	// main sequencer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			cycle_reg <= 1'b0;
			ready_reg <= 1'b1;
			word_count_reg <= 16'h0000;
			bus_address_reg <= 16'h0000;
			base_reg <= `DMAUCI_BASE_RESET;
			vector_reg <= `DMAUCI_VECTOR_RESET;
			user_data_out <= 16'h0000;
			go_pulse <= 1'b0;
			bus_active <= 1'b0;
			bus_addr <= 18'h00000;
			bus_ctrl_n <= 2'h3;
			bus_wdata <= 16'h0000;
			cur_type_reg <= 2'h0;
			end_trig <= 1'b0;
		end else if (bus_init) begin
			state_reg <= ST_IDLE;
			cycle_reg <= 1'b0;
			ready_reg <= 1'b1;
			user_data_out <= 16'h0000;
			go_pulse <= 1'b0;
			bus_active <= 1'b0;
			bus_ctrl_n <= 2'h3;
			end_trig <= 1'b0;
		end else begin
			go_pulse <= 1'b0;
			end_trig <= 1'b0;
			// falling request edge primes a cycle; a write of cycle also primes
			if (req_fall) begin
				cycle_reg <= 1'b1;
			end
			if (wr_pend_reg) begin
				if (wr_addr_reg == `DMAUCI_OFF_CTRL) begin
					if (hwdata[`DMAUCI_CTRL_GO]) begin
						ready_reg <= 1'b0;
						go_pulse <= 1'b1;
					end
					if (hwdata[`DMAUCI_CTRL_CYCLE]) begin
						cycle_reg <= 1'b1;
					end
				end else if (wr_addr_reg == `DMAUCI_OFF_WC) begin
					word_count_reg <= hwdata[15:0];
				end else if (wr_addr_reg == `DMAUCI_OFF_BA) begin
					bus_address_reg <= hwdata[15:0];
				end else if (wr_addr_reg == `DMAUCI_OFF_DB) begin
					user_data_out <= hwdata[15:0];
				end else if (wr_addr_reg == `DMAUCI_OFF_CFG) begin
					base_reg <= hwdata[17:0];
					vector_reg <= hwdata[26:18];
				end
			end
			case (state_reg)
				ST_IDLE: begin
					// ready blocks further cycles
					if (cycle_reg & ~ready_reg) begin
						state_reg <= ST_REQ;
					end
				end
				ST_REQ: begin
					if (npr_grant) begin
						state_reg <= ST_RUN;
						cycle_reg <= 1'b0;
						cur_type_reg <= {cycle_type_hi, cycle_type_lo};
						bus_active <= 1'b1;
						bus_addr <= {2'h0, bus_address_reg};
						bus_ctrl_n <= ~{cycle_type_hi, cycle_type_lo};
						bus_wdata <= user_data_in;
					end
				end
				ST_RUN: begin
					if (bus_done) begin
						state_reg <= ST_IDLE;
						bus_active <= 1'b0;
						bus_ctrl_n <= 2'h3;
						end_trig <= 1'b1;
						if (~cur_type_reg[1]) begin
							user_data_out <= bus_rdata;
						end
						if (addr_step_enable) begin
							bus_address_reg <= bus_address_reg + 16'h0002;
						end
						if (count_step_enable) begin
							word_count_reg <= word_count_reg + 16'h0001;
							if (word_count_reg == 16'hFFFF) begin
								ready_reg <= 1'b1;
							end
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	dmauci_pulse #(
		.LEN(END_LEN)
	) u_end (
		.hclk(hclk),
		.hresetn(hresetn),
		.trig(end_trig),
		.pulse(end_cycle)
	);
endmodule
`default_nettype wire

// ===== hdl/dmauci_defs.vh
// Purpose: constants for the dma user cycle interface
// Assumes: ahb-lite register bus, 50 MHz hclk
// Notes: offsets are byte addresses of 32-bit words
`ifndef DMAUCI_DEFS_VH
`define DMAUCI_DEFS_VH
`define DMAUCI_OFF_CTRL 12'h000
`define DMAUCI_OFF_WC 12'h004
`define DMAUCI_OFF_BA 12'h008
`define DMAUCI_OFF_DB 12'h00C
`define DMAUCI_OFF_CFG 12'h010
`define DMAUCI_BASE_RESET 18'o772410
`define DMAUCI_UNIT_STEP 18'o000020
`define DMAUCI_VECTOR_RESET 9'o124
`define DMAUCI_PRIO_LEVEL 3'h5
`define DMAUCI_CT_DATI 2'h0
`define DMAUCI_CT_DATIP 2'h1
`define DMAUCI_CT_DATO 2'h2
`define DMAUCI_CT_DATOB 2'h3
`define DMAUCI_CLK_MHZ 50
`define DMAUCI_END_PULSE_NS 100
`define DMAUCI_END_PULSE_CYC ((`DMAUCI_END_PULSE_NS * `DMAUCI_CLK_MHZ) / 1000)
`define DMAUCI_CTRL_GO 0
`define DMAUCI_CTRL_READY 7
`define DMAUCI_CTRL_CYCLE 8
`endif

// ===== hdl/dmauci_pulse.v
// Purpose: fixed length pulse stretcher
// Assumes: trig is a one-cycle pulse
// Notes: retrigger restarts the count
`timescale 1ns/1ps
`default_nettype none
module dmauci_pulse #(
	parameter [7:0] LEN = 8'h05
) (
	input wire hclk,
	input wire hresetn,
	input wire trig,
	output reg pulse
);
	reg [7:0] cnt_reg;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 8'h00;
			pulse <= 1'b0;
		end else if (trig) begin
			cnt_reg <= LEN - 8'h01;
			pulse <= 1'b1;
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end else begin
			pulse <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== dv/dmauci_checker.sv
// Purpose: port checker for dmauci_core
// Assumes: one clock domain
// Notes: bound in the testbench
`timescale 1ns/1ps
`default_nettype none
module dmauci_checker (
	input wire hclk,
	input wire hresetn,
	input wire [2:0] irq_level,
	input wire bus_active,
	input wire [1:0] bus_ctrl_n,
	input wire cycle_type_hi,
	input wire cycle_type_lo,
	input wire [15:0] bus_wdata,
	input wire [15:0] user_data_in,
	input wire cycle_req_a,
	input wire cycle_req_b,
	input wire busy,
	input wire npr_req,
	input wire npr_grant,
	input wire end_cycle,
	input wire ready,
	input wire bus_done,
	input wire [15:0] user_data_out,
	input wire [15:0] bus_rdata
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_LEVEL: assert property (irq_level == 3'h5) else $error("bad irq level");
	AST_CTRL: assert property (bus_active |-> bus_ctrl_n == ~{cycle_type_hi, cycle_type_lo})
		else $error("bad bus control");
	AST_WDATA: assert property (bus_active && !bus_ctrl_n[1] |-> bus_wdata == user_data_in)
		else $error("bad write data");
	AST_FALL: assert property ($fell(cycle_req_a || cycle_req_b) |-> ##[1:3] busy)
		else $error("no busy after request");
	AST_RISE: assert property ($rose(cycle_req_a || cycle_req_b) && !busy |=> !busy)
		else $error("busy on rising request");
	AST_GRANT: assert property (npr_req && npr_grant |=> bus_active)
		else $error("no cycle after grant");
	AST_END: assert property ($fell(bus_active) |=> end_cycle [*5] ##1 !end_cycle)
		else $error("bad end pulse");
	AST_IDLE: assert property ($fell(bus_active) |-> !busy) else $error("busy stuck");
	AST_READY: assert property (ready |-> !npr_req) else $error("request while ready");
	AST_RDATA: assert property (bus_done && bus_active && bus_ctrl_n[1] |=>
		user_data_out == $past(bus_rdata)) else $error("bad read data");
endmodule
`default_nettype wire

// ===== dv/dmauci_udev.sv
// Purpose: user device model issuing cycle requests
// Assumes: start is a one-cycle pulse
// Notes: sel picks which request line pulses
`timescale 1ns/1ps
`default_nettype none
module dmauci_udev (
	input wire logic hclk,
	input wire logic start,
	input wire logic sel,
	output logic cycle_req_a,
	output logic cycle_req_b
);
	logic [2:0] cnt_reg = 3'h0;
	always @(posedge hclk) begin
		if (start)
			cnt_reg <= 3'h5;
		else if (cnt_reg != 3'h0)
			cnt_reg <= cnt_reg - 3'h1;
	end
	// five cycles gives the 100 ns minimum width
	assign cycle_req_a = (cnt_reg != 3'h0) && !sel;
	assign cycle_req_b = (cnt_reg != 3'h0) && sel;
endmodule
`default_nettype wire

// ===== dv/test_dmauci_core.sv
// Purpose: testbench for dmauci_core
// Assumes: zero wait ahb slave
// Notes: bus side answered by simple logic here
`timescale 1ns/1ps
`default_nettype none
`include "dmauci_defs.vh"
module test_dmauci_core;
	logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, start = 1'b0, sel = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [1:0] htrans = 2'h0;
	logic cycle_type_hi = 1'b0, cycle_type_lo = 1'b0, npr_grant = 1'b0, bus_done = 1'b0;
	logic count_step_enable = 1'b1, addr_step_enable = 1'b1;
	logic [15:0] user_data_in = 16'h5A3C;
	wire hsel = 1'b1;
	logic bus_init = 1'b0;
	wire [2:0] hsize = 3'h2;
	wire [15:0] bus_rdata = 16'hA5C3;
	wire hreadyout, hresp, busy, end_cycle, ready, go_pulse, npr_req, bus_active;
	wire cycle_req_a, cycle_req_b;
	wire hready = hreadyout;
	wire [31:0] hrdata;
	wire [15:0] user_data_out, bus_wdata;
	wire [17:0] bus_addr, reg_base;
	wire [1:0] bus_ctrl_n;
	wire [2:0] irq_level;
	wire [8:0] irq_vector;
	int err_count = 0, num_checks = 0, cyc = 0;
	dmauci_core uut (.*);
	dmauci_udev udev (.*);
	always #10 hclk = ~hclk;
	task close_out;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	// second argument low on the pause read keeps count and address still
	task run(input logic [1:0] t, input logic en);
		{cycle_type_hi, cycle_type_lo} <= t;
		count_step_enable <= en;
		addr_step_enable <= en;
		sel <= t[0];
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
		while (end_cycle !== 1'b1) @(negedge hclk);
		repeat (8) @(posedge hclk);
	endtask
	always @(posedge hclk) begin
		npr_grant <= npr_req;
		bus_done <= bus_active && !bus_done;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			close_out;
		end
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, `DMAUCI_OFF_CTRL, 32'h0);
		chk(q & 32'h80, 32'h80);
		chk({14'h0, reg_base}, {14'h0, `DMAUCI_BASE_RESET});
		chk({23'h0, irq_vector}, {23'h0, `DMAUCI_VECTOR_RESET});
		chk({31'h0, hresp}, 32'h0);
		ahb(1'b0, `DMAUCI_OFF_DB, 32'h0);
		chk(q & 32'hFFFF, 32'h5A3C);
		ahb(1'b1, 12'h020, 32'h1234);
		ahb(1'b0, 12'h020, 32'h0);
		chk(q, 32'h0);
		ahb(1'b1, `DMAUCI_OFF_WC, 32'hFFFD);
		ahb(1'b1, `DMAUCI_OFF_BA, 32'h0100);
		ahb(1'b1, `DMAUCI_OFF_CTRL, 32'h1);
		@(negedge hclk);
		chk({31'h0, go_pulse}, 32'h1);
		@(posedge hclk);
		run(2'h0, 1'b1);
		chk({16'h0, user_data_out}, 32'hA5C3);
		chk({14'h0, bus_addr}, 32'h100);
		run(2'h1, 1'b0);
		run(2'h2, 1'b1);
		run(2'h3, 1'b1);
		ahb(1'b0, `DMAUCI_OFF_WC, 32'h0);
		chk(q & 32'hFFFF, 32'h0);
		ahb(1'b0, `DMAUCI_OFF_BA, 32'h0);
		chk(q & 32'hFFFF, 32'h0106);
		ahb(1'b0, `DMAUCI_OFF_CTRL, 32'h0);
		chk(q & 32'h80, 32'h80);
		// ready is set, so a primed cycle must sit without running
		ahb(1'b1, `DMAUCI_OFF_CTRL, 32'h100);
		@(posedge hclk);
		ahb(1'b0, `DMAUCI_OFF_CTRL, 32'h0);
		chk(q & 32'h180, 32'h180);
		chk({31'h0, busy}, 32'h1);
		bus_init <= 1'b1;
		@(posedge hclk);
		bus_init <= 1'b0;
		ahb(1'b0, `DMAUCI_OFF_CTRL, 32'h0);
		chk(q & 32'h180, 32'h80);
		chk({16'h0, user_data_out}, 32'h0);
		close_out;
	end
endmodule
bind dmauci_core dmauci_checker chk_i (.*);
`default_nettype wire
